//--- ewd_pkg.sv
package ewd_pkg;

    // =========================================================
    // extension word fields
    localparam logic [4:0] EXT_OPCODE = 5'h03;
    localparam int OPC_MSB = 15;
    localparam int OPC_LSB = 11;
    localparam int SRC_HI_MSB = 10;
    localparam int SRC_HI_LSB = 7;
    localparam int RSVD_REG_MSB = 10;
    localparam int RSVD_REG_LSB = 9;
    localparam int ZERO_CARRY_POS = 8;
    localparam int RPT_SRC_POS = 7;
    localparam int AL_POS = 6;
    localparam int RSVD_MSB = 5;
    localparam int RSVD_LSB = 4;
    localparam int LOW_MSB = 3;
    localparam int LOW_LSB = 0;

    // =========================================================
    // fields of the following instruction
    localparam int BW_POS = 6;
    localparam int AD_POS = 7;
    localparam int AS_MSB = 5;
    localparam int AS_LSB = 4;
    localparam int F2_MSB = 15;
    localparam int F2_LSB = 10;
    localparam logic [5:0] F2_OPCODE = 6'h04;
    localparam int F1_MSB = 15;
    localparam int F1_LSB = 12;
    localparam logic [3:0] F1_MIN_OPCODE = 4'h4;

    // =========================================================
    // register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam int CTRL_RSVD_CHK_POS = 0;
    localparam logic CTRL_RSVD_CHK_RST = 1'h0;
    localparam int STAT_WORD_LSB = 0;
    localparam int STAT_PEND_POS = 16;
    localparam int STAT_RSVD_ERR_POS = 17;
    localparam int STAT_SIZE_ERR_POS = 18;
    localparam logic [15:0] LAST_EXT_RST = 16'h0000;

    // =========================================================
    // types
    typedef enum logic [1:0] {SIZE_RSVD, SIZE_ADDR, SIZE_WORD, SIZE_BYTE} ewd_size_e;
    typedef enum logic {ST_PLAIN, ST_PREFIXED} ewd_state_e;

    // prefix opcode test, shared by both layouts
    function automatic logic ewd_is_ext(input logic [15:0] w);
        return w[OPC_MSB:OPC_LSB] == EXT_OPCODE;
    endfunction

    // register layout when all operands are registers
    function automatic logic ewd_is_reg_layout(input logic [15:0] w);
        logic f2;
        logic f1;
        f2 = w[F2_MSB:F2_LSB] == F2_OPCODE;
        f1 = w[F1_MSB:F1_LSB] >= F1_MIN_OPCODE;
        return (f2 && w[AS_MSB:AS_LSB] == 2'h0) ||
            (f1 && !w[AD_POS] && w[AS_MSB:AS_LSB] == 2'h0);
    endfunction

    // operand size from size bit and byte/word bit
    function automatic ewd_size_e ewd_size_of(input logic al, input logic bw);
        case ({al, bw})
            2'h1: return SIZE_ADDR;
            2'h2: return SIZE_WORD;
            2'h3: return SIZE_BYTE;
            default: return SIZE_RSVD;
        endcase
    endfunction

endpackage

//--- ewd_wb_regs.sv
`timescale 1ns/1ps
// =========================================================
// wishbone slave holding control, status and counter
module ewd_wb_regs import ewd_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_evt_i,
    input wire logic rsvd_evt_i,
    input wire logic size_evt_i,
    input wire logic pending_i,
    input wire logic [15:0] last_ext_i,
    output logic rsvd_chk_o
);

    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
        $error("ewd_wb_regs: ADDR_W must be 4..32");
    end
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
        $error("ewd_wb_regs: CNT_W must be 1..32");
    end

    logic rsvd_err;
    logic size_err;
    logic [CNT_W-1:0] ext_count;

    // =========================================================
    // decode
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = req & wb_we_i;
    wire hit_ctrl = wb_adr_i == ADDR_W'(REG_CTRL);
    wire hit_stat = wb_adr_i == ADDR_W'(REG_STAT);
    wire hit_count = wb_adr_i == ADDR_W'(REG_COUNT);
    wire wr_ctrl = wr & hit_ctrl & wb_sel_i[0];
    wire clr_rsvd = wr & hit_stat & wb_sel_i[2] & wb_dat_i[STAT_RSVD_ERR_POS];
    wire clr_size = wr & hit_stat & wb_sel_i[2] & wb_dat_i[STAT_SIZE_ERR_POS];

    // read data, unmapped reads zero
    logic [31:0] stat_word;
    assign stat_word = {13'h0000, size_err, rsvd_err, pending_i, last_ext_i};
    wire [31:0] rdata = hit_ctrl ? {31'h0, rsvd_chk_o} :
        hit_stat ? stat_word :
        hit_count ? 32'(ext_count) : 32'h0000_0000;

    // bus handshake, ack one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rdata : 32'h0000_0000;
        end
    end

    // control bit and sticky flags, set beats clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rsvd_chk_o <= CTRL_RSVD_CHK_RST;
            rsvd_err <= 1'b0;
            size_err <= 1'b0;
            ext_count <= '0;
        end else begin
            if (wr_ctrl) begin
                rsvd_chk_o <= wb_dat_i[CTRL_RSVD_CHK_POS];
            end
            rsvd_err <= rsvd_evt_i | (rsvd_err & ~clr_rsvd);
            size_err <= size_evt_i | (size_err & ~clr_size);
            if (ext_evt_i) begin
                ext_count <= ext_count + 1'b1;
            end
        end
    end

endmodule

//--- ewd_decoder.sv
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// =========================================================
// extension word decoder
// takes fetched words, remembers a prefix, and on the next
// instruction word issues one decoded record two cycles later
module ewd_decoder import ewd_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,

    // wishbone register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,

    // instruction fetch
    input wire logic word_valid_i,
    input wire logic [15:0] word_i,

    // cpu state read at issue
    input wire logic carry_flag_i,
    input wire logic [3:0] rpt_reg_val_i,
    output logic [3:0] repeat_count_register_o,

    // decoded record to execute
    output logic dec_valid_o,
    output logic [15:0] dec_inst_o,
    output logic ext_o,
    output logic reg_layout_o,
    output logic addr20_o,
    output ewd_size_e size_o,
    output logic size_rsvd_o,
    output logic carry_in_o,
    output logic carry_from_result_o,
    output logic [3:0] repeat_count_o,
    output logic [3:0] src_hi_o,
    output logic [3:0] dst_hi_o,
    output logic prefix_pending_o
);

    // =========================================================
    // state
    ewd_state_e state;
    ewd_state_e next_state;
    logic [15:0] ext_word;
    logic rsvd_chk;

    // stage one: instruction accepted, register index out
    logic s1_valid;
    logic [15:0] s1_inst;
    logic s1_ext;
    logic s1_reg;
    ewd_size_e s1_size;
    logic s1_zero_carry;
    logic s1_rpt_src;
    logic [3:0] s1_low;
    logic [3:0] s1_src_hi;
    logic [3:0] s1_dst_hi;

    // event pulses to the register block
    logic ext_evt;
    logic rsvd_evt;
    logic size_evt;

    // =========================================================
    // classify the incoming word
    wire take = word_valid_i;
    wire word_is_ext = ewd_is_ext(word_i);
    wire take_ext = take & word_is_ext;
    wire take_inst = take & ~word_is_ext;
    wire prefixed = state == ST_PREFIXED;

    // =========================================================
    // fields of the held prefix
    wire pre_zero_carry = ext_word[ZERO_CARRY_POS];
    wire pre_rpt_src = ext_word[RPT_SRC_POS];
    wire pre_al = ext_word[AL_POS];
    wire [3:0] pre_low = ext_word[LOW_MSB:LOW_LSB];
    wire [3:0] pre_src_hi = ext_word[SRC_HI_MSB:SRC_HI_LSB];
    wire [1:0] pre_rsvd = ext_word[RSVD_MSB:RSVD_LSB];
    wire [1:0] pre_rsvd_reg = ext_word[RSVD_REG_MSB:RSVD_REG_LSB];

    // =========================================================
    // fields of the following instruction
    wire inst_bw = word_i[BW_POS];
    wire inst_reg = ewd_is_reg_layout(word_i);
    wire use_reg = prefixed & inst_reg;
    wire use_nonreg = prefixed & ~inst_reg;

    // operand size: plain instructions take byte/word only
    wire ewd_size_e ext_size = ewd_size_of(pre_al, inst_bw);
    wire ewd_size_e plain_size = inst_bw ? SIZE_BYTE : SIZE_WORD;
    wire ewd_size_e next_size = prefixed ? ext_size : plain_size;

    // zero carry and repetition apply only in register layout
    wire next_zero_carry = use_reg & pre_zero_carry;
    wire next_rpt_src = use_reg & pre_rpt_src;
    wire [3:0] next_low = use_reg ? pre_low : 4'h0;

    // upper address bits apply only in non-register layout
    wire [3:0] next_src_hi = use_nonreg ? pre_src_hi : 4'h0;
    wire [3:0] next_dst_hi = use_nonreg ? pre_low : 4'h0;

    // reserved bits are only checked when software asks
    wire rsvd_bad = (pre_rsvd != 2'h0) | (inst_reg & (pre_rsvd_reg != 2'h0));
    wire next_rsvd_evt = take_inst & prefixed & rsvd_chk & rsvd_bad;
    wire next_size_evt = take_inst & prefixed & (ext_size == SIZE_RSVD);

    // =========================================================
    // prefix tracking: a second prefix replaces the first
    always_comb begin
        next_state = state;
        case (state)
            ST_PLAIN: begin
                if (take_ext) begin
                    next_state = ST_PREFIXED;
                end
            end
            ST_PREFIXED: begin
                if (take_inst) begin
                    next_state = ST_PLAIN;
                end
            end
            default: begin
                next_state = ST_PLAIN;
            end
        endcase
    end

    // state and held prefix word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_PLAIN;
            ext_word <= LAST_EXT_RST;
        end else begin
            state <= next_state;
            if (take_ext) begin
                ext_word <= word_i;
            end
        end
    end

    // event pulses for status and counting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_evt <= 1'b0;
            rsvd_evt <= 1'b0;
            size_evt <= 1'b0;
        end else begin
            ext_evt <= take_ext;
            rsvd_evt <= next_rsvd_evt;
            size_evt <= next_size_evt;
        end
    end

    // =========================================================
    // stage one: capture the decoded instruction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_valid <= 1'b0;
            s1_inst <= 16'h0000;
            s1_ext <= 1'b0;
            s1_reg <= 1'b0;
            s1_size <= SIZE_WORD;
        end else begin
            s1_valid <= take_inst;
            if (take_inst) begin
                s1_inst <= word_i;
                s1_ext <= prefixed;
                s1_reg <= use_reg;
                s1_size <= next_size;
            end
        end
    end

    // stage one: carry, repetition and address extension
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_zero_carry <= 1'b0;
            s1_rpt_src <= 1'b0;
            s1_low <= 4'h0;
            s1_src_hi <= 4'h0;
            s1_dst_hi <= 4'h0;
        end else if (take_inst) begin
            s1_zero_carry <= next_zero_carry;
            s1_rpt_src <= next_rpt_src;
            s1_low <= next_low;
            s1_src_hi <= next_src_hi;
            s1_dst_hi <= next_dst_hi;
        end
    end

    // register index goes out so the file answers next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            repeat_count_register_o <= 4'h0;
        end else if (take_inst) begin
            repeat_count_register_o <= next_rpt_src ? next_low : 4'h0;
        end
    end

    // =========================================================
    // stage two: issue values sampled at execution
    wire [3:0] issue_count = s1_rpt_src ? rpt_reg_val_i : s1_low;
    wire issue_carry = s1_zero_carry ? 1'b0 : carry_flag_i;

    // record valid pulse and instruction word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dec_valid_o <= 1'b0;
            dec_inst_o <= 16'h0000;
            ext_o <= 1'b0;
            reg_layout_o <= 1'b0;
            addr20_o <= 1'b0;
        end else begin
            dec_valid_o <= s1_valid;
            if (s1_valid) begin
                dec_inst_o <= s1_inst;
                ext_o <= s1_ext;
                reg_layout_o <= s1_reg;
                addr20_o <= s1_ext;
            end
        end
    end

    // operand size
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            size_o <= SIZE_WORD;
            size_rsvd_o <= 1'b0;
        end else if (s1_valid) begin
            size_o <= s1_size;
            size_rsvd_o <= s1_size == SIZE_RSVD;
        end
    end

    // carry handling for the following instruction
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carry_in_o <= 1'b0;
            carry_from_result_o <= 1'b0;
        end else if (s1_valid) begin
            carry_in_o <= issue_carry;
            carry_from_result_o <= s1_zero_carry;
        end
    end

    // repetition count and upper address bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            repeat_count_o <= 4'h0;
            src_hi_o <= 4'h0;
            dst_hi_o <= 4'h0;
        end else if (s1_valid) begin
            repeat_count_o <= issue_count;
            src_hi_o <= s1_src_hi;
            dst_hi_o <= s1_dst_hi;
        end
    end

    // prefix pending flag for the fetch stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prefix_pending_o <= 1'b0;
        end else begin
            prefix_pending_o <= next_state == ST_PREFIXED;
        end
    end

    // =========================================================
    // register block
    ewd_wb_regs #(
        .ADDR_W(ADDR_W),
        .CNT_W(CNT_W)
    ) i_ewd_wb_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .ext_evt_i(ext_evt),
        .rsvd_evt_i(rsvd_evt),
        .size_evt_i(size_evt),
        .pending_i(prefixed),
        .last_ext_i(ext_word),
        .rsvd_chk_o(rsvd_chk)
    );

endmodule

//--- ewd_checker_assertions.sv
`timescale 1ns/1ps
// ============================================================
// port checker for the extension word decoder
module ewd_checker import ewd_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic word_valid_i,
    input wire logic [15:0] word_i,
    input wire logic carry_flag_i,
    input wire logic dec_valid_o,
    input wire logic [15:0] dec_inst_o,
    input wire logic ext_o,
    input wire logic reg_layout_o,
    input wire logic addr20_o,
    input wire ewd_size_e size_o,
    input wire logic size_rsvd_o,
    input wire logic carry_in_o,
    input wire logic carry_from_result_o,
    input wire logic [3:0] repeat_count_o,
    input wire logic [3:0] src_hi_o,
    input wire logic [3:0] dst_hi_o,
    input wire logic prefix_pending_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // word classes and expected layout of the issued word
    logic is_pre;
    logic non_pre;
    logic reg_lay;
    assign is_pre = word_valid_i && word_i[15:11] == 5'h03;
    assign non_pre = word_valid_i && word_i[15:11] != 5'h03;
    assign reg_lay = dec_inst_o[5:4] == 2'h0 &&
        (dec_inst_o[15:10] == 6'h04 || (dec_inst_o[15:12] >= 4'h4 && !dec_inst_o[7]));

    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered");
    pending_set_a: assert property (is_pre |=> prefix_pending_o)
        else $error("prefix not held");
    prefix_silent_a: assert property (is_pre |-> ##2 !dec_valid_o)
        else $error("prefix issued a record");
    record_issue_a: assert property (non_pre |-> ##2 (dec_valid_o && dec_inst_o == $past(word_i, 2)))
        else $error("record missing or wrong word");
    carry_sel_a: assert property (dec_valid_o |-> carry_in_o == (!carry_from_result_o && $past(carry_flag_i)))
        else $error("carry input wrong");
    addr_wide_a: assert property (dec_valid_o |-> addr20_o == $past(prefix_pending_o, 2))
        else $error("wide address flag wrong");
    plain_size_a: assert property (dec_valid_o && !ext_o |->
        size_o == (dec_inst_o[6] ? SIZE_BYTE : SIZE_WORD)
        && repeat_count_o == 4'h0 && src_hi_o == 4'h0 && dst_hi_o == 4'h0)
        else $error("plain record fields wrong");
    layout_pick_a: assert property (dec_valid_o && ext_o |-> reg_layout_o == reg_lay)
        else $error("layout choice wrong");
    reg_no_hi_a: assert property (dec_valid_o && reg_layout_o |-> src_hi_o == 4'h0 && dst_hi_o == 4'h0)
        else $error("high bits in register layout");
    nonreg_plain_a: assert property (dec_valid_o && !reg_layout_o |-> repeat_count_o == 4'h0 && !carry_from_result_o)
        else $error("repeat in non-register layout");
    rsvd_flag_a: assert property (dec_valid_o |-> size_rsvd_o == (size_o == SIZE_RSVD))
        else $error("reserved size flag wrong");

    // main scenarios
    cover property (dec_valid_o && ext_o && reg_layout_o);
    cover property (dec_valid_o && ext_o && !reg_layout_o);
    cover property (dec_valid_o && size_rsvd_o);
endmodule

bind ewd_decoder ewd_checker #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) i_ewd_checker (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .word_valid_i(word_valid_i),
    .word_i(word_i), .carry_flag_i(carry_flag_i), .dec_valid_o(dec_valid_o), .dec_inst_o(dec_inst_o),
    .ext_o(ext_o), .reg_layout_o(reg_layout_o), .addr20_o(addr20_o), .size_o(size_o),
    .size_rsvd_o(size_rsvd_o), .carry_in_o(carry_in_o), .carry_from_result_o(carry_from_result_o),
    .repeat_count_o(repeat_count_o), .src_hi_o(src_hi_o), .dst_hi_o(dst_hi_o),
    .prefix_pending_o(prefix_pending_o));

//--- ewd_cpu_model.sv
`timescale 1ns/1ps
// ============================================================
// cpu register file seen by the decoder
module ewd_cpu_model (
    input wire logic [3:0] reg_sel_i,
    output logic [3:0] reg_val_o
);
    // fixed low nibbles, distinct from the register index
    logic [3:0] regs [16];
    initial begin
        for (int k = 0; k < 16; k++) begin
            regs[k] = 4'(k * 7 + 3);
        end
    end

    // read port follows the selected index at once
    assign reg_val_o = regs[reg_sel_i];
endmodule

//--- ewd_decoder_tb.sv
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the extension word decoder
module ewd_decoder_tb import ewd_pkg::*;;
    logic clk_i = 1'b0;
    logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, word_valid_i, carry_flag_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i, rpt_reg_val_i, repeat_count_register_o, repeat_count_o, src_hi_o, dst_hi_o;
    logic [31:0] wb_dat_i, wb_dat_o, q, npre;
    logic [15:0] word_i, dec_inst_o, last_pre, p, w;
    logic dec_valid_o, ext_o, reg_layout_o, addr20_o, size_rsvd_o, carry_in_o, carry_from_result_o;
    logic prefix_pending_o, size_seen;
    ewd_size_e size_o;
    int errors, compares, cycles, seed;

    always #4 clk_i = ~clk_i;

    ewd_decoder #(.ADDR_W(8), .CNT_W(32)) i_ewd_decoder (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .word_valid_i(word_valid_i), .word_i(word_i), .carry_flag_i(carry_flag_i),
        .rpt_reg_val_i(rpt_reg_val_i), .repeat_count_register_o(repeat_count_register_o),
        .dec_valid_o(dec_valid_o), .dec_inst_o(dec_inst_o), .ext_o(ext_o), .reg_layout_o(reg_layout_o),
        .addr20_o(addr20_o), .size_o(size_o), .size_rsvd_o(size_rsvd_o), .carry_in_o(carry_in_o),
        .carry_from_result_o(carry_from_result_o), .repeat_count_o(repeat_count_o),
        .src_hi_o(src_hi_o), .dst_hi_o(dst_hi_o), .prefix_pending_o(prefix_pending_o));

    ewd_cpu_model i_ewd_cpu_model (.reg_sel_i(repeat_count_register_o), .reg_val_o(rpt_reg_val_i));

    // ============================================================
    // expectations
    function automatic logic is_rl(input logic [15:0] i);
        return i[5:4] == 2'h0 && (i[15:10] == 6'h04 || (i[15:12] >= 4'h4 && !i[7]));
    endfunction

    function automatic logic [39:0] exp_rec(input logic hp, input logic [15:0] pw, input logic [15:0] i,
        input logic c);
        logic rl, zcs, nr;
        logic [1:0] sz;
        logic [3:0] ri, rc;
        rl = hp && is_rl(i);
        nr = hp && !rl;
        zcs = rl && pw[8];
        sz = hp ? {pw[6], i[6]} : {1'b1, i[6]};
        ri = (rl && pw[7]) ? pw[3:0] : 4'h0;
        rc = rl ? (pw[7] ? 4'(ri * 7 + 3) : pw[3:0]) : 4'h0;
        return {i, hp, rl, hp, sz, sz == 2'h0, c && !zcs, zcs, rc, nr ? pw[10:7] : 4'h0, nr ? pw[3:0] : 4'h0, ri};
    endfunction

    // ============================================================
    // compares and closing
    task automatic cmp_rec(input logic [39:0] g, input logic [39:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t record got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t register got %h exp %h", $time, g, e);
        end
    endtask

    task automatic summarize();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ============================================================
    // bus and fetch drivers
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        // wait for ack; the hang guard ends it if ack never comes
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        wb_xfer(1'b0, a, 4'hf, 32'h0);
        cmp_reg(q, e);
    endtask

    // optional stale prefix, optional prefix, then the instruction back to back
    task automatic run_op(input logic [1:0] np, input logic [15:0] p0, input logic [15:0] pw, input logic [15:0] i);
        logic c;
        int n;
        c = 1'($random(seed));
        carry_flag_i <= c;
        if (np == 2'd2) begin
            word_valid_i <= 1'b1;
            word_i <= p0;
            npre++;
            @(posedge clk_i);
        end
        if (np != 2'd0) begin
            word_valid_i <= 1'b1;
            word_i <= pw;
            npre++;
            last_pre = pw;
            size_seen |= {pw[6], i[6]} == 2'h0;
            @(posedge clk_i);
        end
        word_valid_i <= 1'b1;
        word_i <= i;
        @(posedge clk_i);
        word_valid_i <= 1'b0;
        n = 0;
        while (dec_valid_o !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 8) begin
            errors++;
            $display("[FAIL] %0t no record", $time);
        end
        cmp_rec({dec_inst_o, ext_o, reg_layout_o, addr20_o, size_o, size_rsvd_o, carry_in_o, carry_from_result_o,
            repeat_count_o, src_hi_o, dst_hi_o, repeat_count_register_o},
            exp_rec(np != 2'd0, pw, i, c));
    endtask

    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            summarize();
        end
    end

    // ============================================================
    // main sequence
    initial begin
        seed = 32'hc66c;
        {errors, compares, cycles, npre, size_seen, last_pre} = '0;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, word_valid_i, carry_flag_i} = 6'h20;
        {wb_adr_i, wb_sel_i, wb_dat_i, word_i} = '0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h0c, 32'h0);
        wb_xfer(1'b1, 8'h00, 4'hf, 32'hffffffff);
        rd_chk(8'h00, 32'h1);
        // every zero-carry, repeat source and size code in register layout
        for (int k = 0; k < 16; k++) begin
            run_op(2'd1, 0, {5'h03, 2'h0, k[0], k[1], k[2], 2'h0, 4'(k * 5)}, 16'h5408 | 16'(k[3] << 6));
        end
        run_op(2'd1, 0, 16'h1fca, 16'h4592);
        run_op(2'd1, 0, 16'h1800, 16'h4592);
        run_op(2'd1, 0, 16'h1840, 16'h1005);
        run_op(2'd2, 16'h1fca, 16'h1840, 16'h5408);
        run_op(2'd0, 0, 0, 16'h17ff);
        run_op(2'd0, 0, 0, 16'h2000);
        // reserved bits set with checking on, sticky error expected
        run_op(2'd1, 0, 16'h1870, 16'h4592);
        // random words with reserved bits kept zero
        for (int k = 0; k < 40; k++) begin
            q = $random(seed);
            w = 16'($random(seed));
            if (q[0]) begin
                w[14] = 1'b1;
                w[7] = 1'b0;
                w[5:4] = 2'h0;
            end
            if (w[15:11] == 5'h03) w[15] = 1'b1;
            p = {5'h03, q[11:1]};
            p[5:4] = 2'h0;
            if (is_rl(w)) p[10:9] = 2'h0;
            run_op({1'b0, q[12]}, 0, p, w);
        end
        rd_chk(8'h04, {13'h0, size_seen, 1'b1, 1'b0, last_pre});
        rd_chk(8'h08, npre);
        wb_xfer(1'b1, 8'h04, 4'hf, 32'h0006ffff);
        rd_chk(8'h04, {16'h0, last_pre});
        summarize();
    end
endmodule
